// ===== logic/dsh_params.svh
`ifndef DSH_PARAMS_SVH
`define DSH_PARAMS_SVH

`define DSH_OFF_DST_SGL 12'h380
`define DSH_OFF_SRC_LST 12'h388
`define DSH_OFF_DST_LST 12'h390
`define DSH_OFF_CFG 12'h398
`define DSH_ADDR_W 12
`define DSH_NUM_CH 3
`define DSH_REQ_LSB 0
`define DSH_WE_LSB 8
`define DSH_CFG_EN_BIT 0
`define DSH_RST_REQ 3'h0
`define DSH_RST_EN 1'h0

`endif

// ===== logic/dsh_pkg.sv
package dsh_pkg;
	typedef struct packed {
		logic [2:0] dest_single_req;
		logic [2:0] source_last_flag;
		logic [2:0] dest_last_flag;
		logic dma_enable;
	} dsh_ctrl_t;

	typedef enum logic [1:0] {
		DSH_SEL_DST_SGL,
		DSH_SEL_SRC_LST,
		DSH_SEL_DST_LST,
		DSH_SEL_CFG
	} dsh_sel_t;
endpackage

// ===== logic/dsh_regs.sv
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/10ps
`include "dsh_params.svh"

module dsh_regs (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output dsh_pkg::dsh_ctrl_t ctrl
);
	logic wr_pend_q;
	logic wr_hit_q;
	dsh_pkg::dsh_sel_t wr_sel_q;
	logic [2:0] dst_sgl_q;
	logic [2:0] src_lst_q;
	logic [2:0] dst_lst_q;
	logic dma_en_q;
	logic [2:0] dst_sgl_d;
	logic [2:0] src_lst_d;
	logic [2:0] dst_lst_d;
	logic dma_en_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic take;
	logic hit;
	dsh_pkg::dsh_sel_t sel;

	// Masked update: a channel changes only when its enable is set.
	function automatic logic [2:0] masked(input logic [2:0] old,
		input logic [31:0] wd);
		logic [2:0] we;
		logic [2:0] nv;
		we = wd[`DSH_WE_LSB +: `DSH_NUM_CH];
		nv = wd[`DSH_REQ_LSB +: `DSH_NUM_CH];
		masked = (old & ~we) | (nv & we);
	endfunction

	function automatic logic [31:0] req_word(input logic [2:0] v);
		req_word = {29'h0, v};
	endfunction

	assign take = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;

	always_comb begin
		hit = 1'b1;
		sel = dsh_pkg::DSH_SEL_CFG;
		unique case (haddr[`DSH_ADDR_W-1:0])
			`DSH_OFF_DST_SGL: sel = dsh_pkg::DSH_SEL_DST_SGL;
			`DSH_OFF_SRC_LST: sel = dsh_pkg::DSH_SEL_SRC_LST;
			`DSH_OFF_DST_LST: sel = dsh_pkg::DSH_SEL_DST_LST;
			`DSH_OFF_CFG: sel = dsh_pkg::DSH_SEL_CFG;
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_hit_q <= 1'b0;
			wr_sel_q <= dsh_pkg::DSH_SEL_CFG;
		end else begin
			wr_pend_q <= take && hwrite;
			wr_hit_q <= take && hwrite && hit;
			wr_sel_q <= sel;
		end
	end

	// Read data is captured at the address phase; unmapped reads give zero.
	// A read right behind a write to the same register sees the old value.
	always_comb begin
		rdata_d = rdata_q;
		if (take && !hwrite && hit) begin
			unique case (sel)
				dsh_pkg::DSH_SEL_DST_SGL: rdata_d = req_word(dst_sgl_q);
				dsh_pkg::DSH_SEL_SRC_LST: rdata_d = req_word(src_lst_q);
				dsh_pkg::DSH_SEL_DST_LST: rdata_d = req_word(dst_lst_q);
				dsh_pkg::DSH_SEL_CFG: rdata_d = {31'h0, dma_en_q};
			endcase
		end else if (take) begin
			rdata_d = 32'h0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	always_comb begin
		dst_sgl_d = dst_sgl_q;
		if (wr_hit_q && wr_sel_q == dsh_pkg::DSH_SEL_DST_SGL) begin
			dst_sgl_d = masked(dst_sgl_q, hwdata);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dst_sgl_q <= `DSH_RST_REQ;
		end else begin
			dst_sgl_q <= dst_sgl_d;
		end
	end

	always_comb begin
		src_lst_d = src_lst_q;
		if (wr_hit_q && wr_sel_q == dsh_pkg::DSH_SEL_SRC_LST) begin
			src_lst_d = masked(src_lst_q, hwdata);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_lst_q <= `DSH_RST_REQ;
		end else begin
			src_lst_q <= src_lst_d;
		end
	end

	always_comb begin
		dst_lst_d = dst_lst_q;
		if (wr_hit_q && wr_sel_q == dsh_pkg::DSH_SEL_DST_LST) begin
			dst_lst_d = masked(dst_lst_q, hwdata);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dst_lst_q <= `DSH_RST_REQ;
		end else begin
			dst_lst_q <= dst_lst_d;
		end
	end

	always_comb begin
		dma_en_d = dma_en_q;
		if (wr_hit_q && wr_sel_q == dsh_pkg::DSH_SEL_CFG) begin
			dma_en_d = hwdata[`DSH_CFG_EN_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dma_en_q <= `DSH_RST_EN;
		end else begin
			dma_en_q <= dma_en_d;
		end
	end

	// The write enables are strobes, not storage, so they read as zero.
	assign ctrl.dest_single_req = dst_sgl_q;
	assign ctrl.source_last_flag = src_lst_q;
	assign ctrl.dest_last_flag = dst_lst_q;
	assign ctrl.dma_enable = dma_en_q;

	logic unused_ok;
	assign unused_ok = wr_pend_q ^ (|hsize) ^ (|haddr[31:`DSH_ADDR_W]);
endmodule

// ===== tb/dsh_chk.sv
`timescale 1ns/10ps
module dsh_chk (
	input logic hclk,
	input logic hresetn,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [31:0] hwdata,
	input logic [31:0] hrdata,
	input logic hresp,
	input dsh_pkg::dsh_ctrl_t ctrl
);
	// Old state and data, kept one edge late, predict a write's result.
	logic [31:0] d;
	logic [9:0] p;
	wire [9:0] c = ctrl;
	wire w = htrans[1] && hwrite;
	wire r = htrans[1] && !hwrite;
	wire [11:0] a = haddr[11:0];
	function automatic [2:0] m(input [2:0] o);
		return d[10:8] & d[2:0] | ~d[10:8] & o;
	endfunction
	wire [9:0] q = {m(p[9:7]), m(p[6:4]), m(p[3:1]), d[0]};
	always_ff @(posedge hclk) begin
		d <= hwdata;
		p <= c;
	end
	sequence s(x);
		w && a == x ##1 1;
	endsequence
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_dsr_wr: assert property (s(12'h380) |=> c[9:7] == q[9:7])
		else $error("dsr");
	a_slf_wr: assert property (s(12'h388) |=> c[6:4] == q[6:4])
		else $error("slf");
	a_dlf_wr: assert property (s(12'h390) |=> c[3:1] == q[3:1])
		else $error("dlf");
	a_cfg_wr: assert property (s(12'h398) |=> c[0] == q[0])
		else $error("en");
	a_ctrl_cause: assert property ($changed(c) |-> $past(w, 2))
		else $error("chg");
	a_dsr_rd: assert property (r && a == 12'h380 |=>
		hrdata == {29'h0, $past(c[9:7])}) else $error("rd");
	a_slf_rd: assert property (r && a == 12'h388 |=>
		hrdata == {29'h0, $past(c[6:4])}) else $error("rd");
	a_cfg_rd: assert property (r && a == 12'h398 |=>
		hrdata == {31'h0, $past(c[0])}) else $error("rd");
	a_dlf_rd: assert property (r && a == 12'h390 |=>
		hrdata == {29'h0, $past(c[3:1])}) else $error("rd");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("resp");
	c_src: cover property (s(12'h388));
	c_keep: cover property (w ##1 hwdata[10:8] == 3'h0);
	c_rd: cover property (r && a == 12'h398);
endmodule
bind dsh_regs dsh_chk dsh_chk_inst (.*);

// ===== tb/dsh_regs_test.sv
`timescale 1ns/10ps
module dsh_regs_test;
	logic hclk = 1'h0, hresetn = 1'h0, hwrite = 1'h0, hreadyout;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, x = 32'h5;
	dsh_pkg::dsh_ctrl_t ctrl;
	int num_errors = 0, comparisons = 0, cyc = 0, k, m[5];
	dsh_regs dsh_regs_inst (.*, .hsel(1'h1), .hsize(3'h2), .hready(hreadyout),
		.hresp());
	always #50 hclk = ~hclk;
	always @(posedge hclk) if (++cyc > 999) begin
		num_errors++;
		report_and_stop;
	end
	task report_and_stop;
		$display("errors %0d checks %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [41:0] s, v);
		comparisons++;
		if (s !== v) begin
			num_errors++;
			$display("ERROR rdata,ctrl expected %h seen %h", v, s);
		end
	endtask
	task xfer(input logic w);
		// Upper address bits are noise, since only bits 11:0 decode.
		haddr <= {x[31:12], 6'h0E, k[2:0], 3'h0};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= x;
		do @(posedge hclk); while (hreadyout !== 1'h1);
	endtask
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'h1;
		for (int i = 0; i < 45; i++) begin
			x ^= x << 13;
			x ^= x >> 17;
			x ^= x << 5;
			k = i < 5 ? i : x[20:18] % 5;
			if (i > 4) begin
				xfer(1'h1);
				if (k < 3) m[k] = m[k] & ~x[10:8] | x[2:0] & x[10:8];
				if (k == 3) m[3] = x[0];
			end
			xfer(1'h0);
			chk({hrdata, ctrl},
				{m[k], m[0][2:0], m[1][2:0], m[2][2:0], m[3][0]});
		end
		report_and_stop;
	end
endmodule
